// file: inc/watchdog_fault_supervisor_params.svh
// Constants for the watchdog and fault supervisor
// Contract
// - No fault while kick edges within 16 ms
// - Fault when kick edge spacing exceeds 24 ms
// - Stuck kick pulses reset low for 2 ms
// - Stuck period is start, timeout, pulse
// - Rate pin fault drives reset, power good stays
// - Thermal, supply, reference undervoltage force master reset
// - Pump cap pin fault gives pump undervoltage reset
// - Pump output short gives master reset
// - Reference overvoltage shows all rails over/under
`ifndef WATCHDOG_FAULT_SUPERVISOR_PARAMS_SVH
`define WATCHDOG_FAULT_SUPERVISOR_PARAMS_SVH
`define CLOCK_HZ          25000000
`define WD_PASS_MS        16
`define WD_FAIL_MS        24
`define WD_TIMEOUT_MS     20
`define WD_FAULT_PULSE_MS 2
`define WD_START_MS       10
`define MS_CYCLES(ms)     ((ms) * (`CLOCK_HZ / 1000))
`define RAIL_COUNT        4
`endif

// file: inc/watchdog_fault_supervisor_pkg.sv
// Types for the watchdog and fault supervisor
package watchdog_fault_supervisor_pkg;
  typedef enum logic [1:0] {WD_START, WD_WATCH, WD_PULSE} wd_state_t;
  typedef struct packed {
    logic thermal_shutdown;
    logic supply_undervoltage;
    logic regulation_reference_uv;
    logic monitor_reference_uv;
    logic regulation_reference_ov;
    logic monitor_reference_ov;
    logic pump_undervoltage;
    logic pump_output_short;
    logic pump_cap_a_fault;
    logic pump_cap_b_fault;
    logic watchdog_rate_pin_fault;
  } fault_in_t;
endpackage

// file: rtl/watchdog_fault_supervisor.sv
// Watchdog kick supervisor and fault to master reset logic
`timescale 1ns/1ps
`include "watchdog_fault_supervisor_params.svh"
module watchdog_fault_supervisor #(
  parameter int unsigned START_CYCLES   = `MS_CYCLES(`WD_START_MS),
  parameter int unsigned TIMEOUT_CYCLES = `MS_CYCLES(`WD_TIMEOUT_MS),
  parameter int unsigned PULSE_CYCLES   = `MS_CYCLES(`WD_FAULT_PULSE_MS),
  parameter int unsigned RAILS          = `RAIL_COUNT
) (
  input  wire logic                                      clock,
  input  wire logic                                      rst,
  input  wire logic                                      kick,
  input  wire watchdog_fault_supervisor_pkg::fault_in_t  faults,
  output logic                                           reset_out_low,
  output logic                                           five_volt_good,
  output logic                                           master_reset_event,
  output logic                                           regulators_on,
  output logic [RAILS-1:0]                               rail_overvoltage,
  output logic [RAILS-1:0]                               rail_undervoltage,
  output logic                                           watchdog_fault
);
  // Refuse counts and widths that the logic cannot serve
  if (TIMEOUT_CYCLES < 2 || PULSE_CYCLES < 1 || START_CYCLES < 1 || RAILS < 1)
  begin : g_bad_params
    $error("watchdog_fault_supervisor: bad parameters");
  end

  watchdog_fault_supervisor_pkg::fault_in_t  fault_s1_q;
  watchdog_fault_supervisor_pkg::fault_in_t  fault_s2_q;
  watchdog_fault_supervisor_pkg::wd_state_t  state_q;
  logic        kick_s1_q;
  logic        kick_s2_q;
  logic        kick_prev_q;
  logic [31:0] count_q;
  logic        master_d;
  logic        kick_rise;

  // True while the watchdog is in its fault pulse
  function automatic logic in_pulse(input watchdog_fault_supervisor_pkg::wd_state_t s);
    return s == watchdog_fault_supervisor_pkg::WD_PULSE;
  endfunction

  // True while either reference reads too high
  function automatic logic reference_high(input watchdog_fault_supervisor_pkg::fault_in_t f);
    return f.regulation_reference_ov | f.monitor_reference_ov;
  endfunction

  // Two stage synchronisers for pins
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      kick_s1_q   <= 1'b0;
      kick_s2_q   <= 1'b0;
      kick_prev_q <= 1'b0;
      fault_s1_q  <= '0;
      fault_s2_q  <= '0;
    end
    else
    begin
      kick_s1_q   <= kick;
      kick_s2_q   <= kick_s1_q;
      kick_prev_q <= kick_s2_q;
      fault_s1_q  <= faults;
      fault_s2_q  <= fault_s1_q;
    end
  end

  assign kick_rise = kick_s2_q & ~kick_prev_q;

  // Master reset from non-latched faults
  always_comb
  begin
    master_d = fault_s2_q.thermal_shutdown | fault_s2_q.supply_undervoltage
             | fault_s2_q.regulation_reference_uv | fault_s2_q.monitor_reference_uv
             | fault_s2_q.pump_undervoltage | fault_s2_q.pump_cap_a_fault
             | fault_s2_q.pump_cap_b_fault | fault_s2_q.pump_output_short;
  end

  // Watchdog: start delay, timeout window, fault pulse
  always_ff @(posedge clock)
  begin
    if (rst || master_d)
    begin
      state_q <= watchdog_fault_supervisor_pkg::WD_START;
      count_q <= 32'h0000_0000;
    end
    else
    begin
      unique case (state_q)
        watchdog_fault_supervisor_pkg::WD_START:
        begin
          if (count_q >= START_CYCLES - 1)
          begin
            state_q <= watchdog_fault_supervisor_pkg::WD_WATCH;
            count_q <= 32'h0000_0000;
          end
          else
            count_q <= count_q + 32'h0000_0001;
        end
        watchdog_fault_supervisor_pkg::WD_WATCH:
        begin
          if (kick_rise)
            count_q <= 32'h0000_0000;
          else if (count_q >= TIMEOUT_CYCLES - 1)
          begin
            state_q <= watchdog_fault_supervisor_pkg::WD_PULSE;
            count_q <= 32'h0000_0000;
          end
          else
            count_q <= count_q + 32'h0000_0001;
        end
        watchdog_fault_supervisor_pkg::WD_PULSE:
        begin
          if (count_q >= PULSE_CYCLES - 1)
          begin
            state_q <= watchdog_fault_supervisor_pkg::WD_START;
            count_q <= 32'h0000_0000;
          end
          else
            count_q <= count_q + 32'h0000_0001;
        end
        default:
        begin
          state_q <= watchdog_fault_supervisor_pkg::WD_START;
          count_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Master reset and regulator enable
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      master_reset_event <= 1'b0;
      regulators_on      <= 1'b0;
    end
    else
    begin
      master_reset_event <= master_d;
      regulators_on      <= ~master_d;
    end
  end

  // Rail monitor flags from reference faults
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rail_overvoltage  <= '0;
      rail_undervoltage <= '0;
    end
    else
    begin
      rail_overvoltage  <= {RAILS{fault_s2_q.regulation_reference_ov}};
      rail_undervoltage <= {RAILS{fault_s2_q.monitor_reference_ov}};
    end
  end

  // Watchdog fault pulse flag
  always_ff @(posedge clock)
  begin
    if (rst)
      watchdog_fault <= 1'b0;
    else
      watchdog_fault <= in_pulse(state_q);
  end

  // Power good stays high on a rate pin fault
  always_ff @(posedge clock)
  begin
    if (rst)
      five_volt_good <= 1'b0;
    else
      five_volt_good <= ~(master_d | reference_high(fault_s2_q));
  end

  // Active low reset output
  always_ff @(posedge clock)
  begin
    if (rst)
      reset_out_low <= 1'b0;
    else
      reset_out_low <= ~(master_d | fault_s2_q.watchdog_rate_pin_fault
                         | reference_high(fault_s2_q)
                         | in_pulse(state_q));
  end
endmodule // watchdog_fault_supervisor

// file: tb/wfs_checker_assertions.sv
// Concurrent checks on the watchdog fault supervisor ports
`timescale 1ns/1ps
module wfs_checker #(
  parameter int unsigned PULSE_CYCLES = 5
) (
  input wire logic                                     clock,
  input wire logic                                     rst,
  input wire logic                                     kick,
  input wire watchdog_fault_supervisor_pkg::fault_in_t faults,
  input wire logic                                     reset_out_low,
  input wire logic                                     five_volt_good,
  input wire logic                                     master_reset_event,
  input wire logic                                     regulators_on,
  input wire logic [3:0]                               rail_overvoltage,
  input wire logic [3:0]                               rail_undervoltage,
  input wire logic                                     watchdog_fault
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int unsigned pulse_cnt_q;
  always_ff @(posedge clock)
    pulse_cnt_q <= (rst || !watchdog_fault) ? 0 : pulse_cnt_q + 1;
  sequence s_held(f);
    (!rst && f) [*4];
  endsequence
  sequence s_master;
    master_reset_event && !regulators_on && !reset_out_low && !five_volt_good;
  endsequence
  a_core_master: assert property (s_held(faults[10:7] != 0) |-> s_master)
    else $error("core fault gave no master reset");
  a_cap_master: assert property (s_held(faults[4] || faults[2] || faults[1]) |-> s_master)
    else $error("pump cap fault gave no master reset");
  a_short_master: assert property (s_held(faults.pump_output_short) |-> s_master)
    else $error("pump short gave no master reset");
  a_rate_reset: assert property (s_held(faults == 11'h001) |-> !reset_out_low && five_volt_good && regulators_on)
    else $error("rate pin fault response wrong");
  a_reg_over: assert property (s_held(faults == 11'h040) |-> rail_overvoltage == 4'hf && !five_volt_good)
    else $error("rails not all over");
  a_mon_over: assert property (s_held(faults == 11'h020) |-> rail_undervoltage == 4'hf && !reset_out_low)
    else $error("rails not all under");
  a_not_latched: assert property (s_held(faults == 11'h000) |-> !master_reset_event && regulators_on)
    else $error("master reset stayed after fault cleared");
  a_pulse_len: assert property (!$past(rst) && $fell(watchdog_fault) |-> pulse_cnt_q == PULSE_CYCLES)
    else $error("watchdog pulse length wrong");
  a_pulse_low: assert property (watchdog_fault |-> !reset_out_low)
    else $error("watchdog pulse without reset low");
endmodule // wfs_checker
bind watchdog_fault_supervisor wfs_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_wfs_checker (.*);

// file: tb/kick_host.sv
// Host model that kicks the watchdog at a set spacing
`timescale 1ns/1ps
module kick_host (
  input  wire logic       clock,
  input  wire logic [7:0] period,
  output logic            kick = 1'b0
);
  logic [7:0] cnt_q = 8'h00;
  always @(posedge clock)
  begin
    cnt_q <= (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
    kick  <= (period != 8'h00) && (cnt_q < period / 2);
  end
endmodule // kick_host

// file: tb/watchdog_fault_supervisor_tb.sv
// Testbench for the watchdog fault supervisor
`timescale 1ns/1ps
module watchdog_fault_supervisor_tb;
  logic clock = 1'b0, rst = 1'b1, kick, rol, pg, mre, ron, wdf;
  logic [7:0] period = 8'h1e;
  logic [3:0] rov, ruv;
  watchdog_fault_supervisor_pkg::fault_in_t faults = '0;
  int n_errors = 0, checks_done = 0;
  always #20 clock = ~clock;
  kick_host u_kick_host (.clock(clock), .period(period), .kick(kick));
  watchdog_fault_supervisor #(.START_CYCLES(20), .TIMEOUT_CYCLES(50), .PULSE_CYCLES(5)) u_watchdog_fault_supervisor (
    .clock(clock), .rst(rst), .kick(kick), .faults(faults), .reset_out_low(rol), .five_volt_good(pg),
    .master_reset_event(mre), .regulators_on(ron), .rail_overvoltage(rov), .rail_undervoltage(ruv),
    .watchdog_fault(wdf));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Counts cycles until reset output reaches a level
  task automatic wait_rol(input logic lvl, output int n);
    n = 0;
    while (rol !== lvl)
    begin
      step(1);
      n++;
      if (n > 400)
      begin
        n_errors++;
        summarize();
      end
    end
  endtask
  task automatic steady_kicks();
    int lows = 0;
    step(40);
    repeat (300)
    begin
      step(1);
      lows += (rol !== 1'b1);
    end
    check("steady_lows", 8'(lows), 8'h00);
  endtask
  task automatic stuck_kick();
    int n;
    period = 8'h00;
    wait_rol(1'b0, n);
    wait_rol(1'b1, n);
    check("pulse_len", 8'(n), 8'h05);
    wait_rol(1'b0, n);
    check("pulse_gap", 8'(n + 5), 8'h4b);
  endtask
  task automatic slow_kicks();
    int n;
    wait_rol(1'b1, n);
    period = 8'h3c;
    wait_rol(1'b0, n);
    check("slow_fault", 8'(wdf), 8'h01);
  endtask
  task automatic fault_table();
    logic mst;
    period = 8'h1e;
    for (int i = 0; i < 11; i++)
    begin
      mst = (i >= 7) || (i >= 1 && i <= 4);
      faults = 11'(1 << i);
      step(4);
      check("master", 8'(mre), 8'(mst));
      check("rst_out", 8'(rol), 8'h00);
      check("pgood", 8'(pg), 8'(i == 0));
      check("regs_on", 8'(ron), 8'(!mst));
      check("rails_ov", 8'(rov), (i == 6) ? 8'h0f : 8'h00);
      check("rails_uv", 8'(ruv), (i == 5) ? 8'h0f : 8'h00);
      faults = '0;
      step(4);
      check("unlatched", 8'(mre), 8'h00);
    end
  endtask
  initial
  begin
    step(10);
    rst = 1'b0;
    steady_kicks();
    stuck_kick();
    slow_kicks();
    fault_table();
    summarize();
  end
endmodule // watchdog_fault_supervisor_tb
